/* logic/port_a_ctrl_cfg.svh */
// Named constants for the port A offset, loopback and mailbox control.
// Assumes inclusion by bare name from the design and verification files.
`ifndef PORT_A_CTRL_CFG_SVH
`define PORT_A_CTRL_CFG_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define DATA_W          36
`define OFS_W_DEFAULT   11
`define TX_DEPTH        16
`define BUS_ADDR_W      5

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_STATUS     5'h00
`define ADDR_FIRST_B    5'h04
`define ADDR_FIRST_A    5'h08
`define ADDR_SECOND_B   5'h0c
`define ADDR_SECOND_A   5'h10
`define ADDR_CTRL       5'h14
`define ADDR_LEVEL      5'h18

// ****************************************************************
// Control and status fields
// ****************************************************************
`define CTRL_LOOP_ALLOW 0
`define CTRL_QWRITE_EN  1
`define CTRL_RESET      2'h3
`define ST_METHOD_LSB   0
`define ST_DONE_BIT     2
`define ST_LOOP_BIT     3
`define ST_COUNT_LSB    8

// ****************************************************************
// Strap codes and preset offsets
// ****************************************************************
`define STRAP_PARALLEL  3'h5
`define STRAP_SERIAL    2'h3
`define PRESET_0        16'h0008
`define PRESET_1        16'h0010
`define PRESET_2        16'h0040
`define PRESET_3        16'h0100
`define PRESET_4        16'h0400
`define OFS_REG_COUNT   4

`endif

/* logic/port_a_ctrl_pkg.sv */
// Shared types for the port A offset, loopback and mailbox control.
// Assumes the configuration header is compiled alongside it.
package port_a_ctrl_pkg;

	// ****************************************************************
	// Enumerations
	// ****************************************************************

	// Offset programming method chosen while master reset is released.
	typedef enum logic [1:0] {
		METHOD_PRESET   = 2'b00,
		METHOD_PARALLEL = 2'b01,
		METHOD_SERIAL   = 2'b10
	} method_t;

	// Phase of the control: strap capture, offset loading, normal running.
	typedef enum logic [1:0] {
		PH_STRAP = 2'b00,
		PH_LOAD  = 2'b01,
		PH_RUN   = 2'b10
	} phase_t;

endpackage

/* logic/tx_fifo.sv */
// Synchronous FIFO that feeds the transmit queue from port A or loopback.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ps
`include "port_a_ctrl_cfg.svh"

module tx_fifo #(
	parameter int WIDTH = `DATA_W,
	parameter int DEPTH = `TX_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	// Pointer arithmetic below wraps naturally only for a power of two.
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("tx_fifo depth must be a power of two of at least two");
	end

	// ****************************************************************
	// State
	// ****************************************************************

	// All pointer and flag state of the buffer.
	typedef struct packed {
		logic [AW:0] wr_ptr;   // Write pointer with wrap bit.
		logic [AW:0] rd_ptr;   // Read pointer with wrap bit.
		logic        ready;    // Registered not-full flag.
		logic        valid;    // Registered not-empty flag.
	} fifo_state_t;

	fifo_state_t      s_q;                 // Registered state.
	fifo_state_t      s_d;                 // Next state.
	logic [WIDTH-1:0] mem [DEPTH];         // Storage words.
	logic             push;                // A word enters this cycle.
	logic             pop;                 // A word leaves this cycle.
	logic [AW:0]      fill;                // Words held after this cycle.

	assign push = in_valid && s_q.ready;
	assign pop  = out_ready && s_q.valid;

	// Next pointers and the honest full and empty flags.
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		fill = s_d.wr_ptr - s_d.rd_ptr;
		s_d.ready = (fill != (AW+1)'(DEPTH));
		s_d.valid = (fill != '0);
	end

	// State register.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Storage write; the array needs no reset.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[s_q.wr_ptr[AW-1:0]] <= in_data;
		end
	end

	assign in_ready  = s_q.ready;
	assign out_valid = s_q.valid;
	assign out_data  = mem[s_q.rd_ptr[AW-1:0]];
	assign level     = s_q.wr_ptr - s_q.rd_ptr;
endmodule

/* logic/port_a_offset_loop_mail_ctrl.sv */
// Port A control: offset register loading, loopback steering, mailbox choice.
// Assumes all port A inputs are synchronous to sys_clk and rst is master reset.
//
// Operation
// - Serial enable sampled on each rising clock.
// - Enable low shifts one serial bit in.
// - Full serial load takes four offset widths.
// - First bit lands first-queue B MSB.
// - Loopback sends receive data into transmit queue.
// - Mail select high picks a mailbox register.
// - Port A outputs mailbox two or receive data.
// - Offsets load preset, parallel, or serial.
// - Strap pins decide method at reset release.
// - Presets are 8, 16, 64, 256, 1024.
`timescale 1ns/1ps
`include "port_a_ctrl_cfg.svh"

module port_a_offset_loop_mail_ctrl
	import port_a_ctrl_pkg::*;
#(
	parameter int OFS_W = `OFS_W_DEFAULT
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   offset_sel1_serial_load_en,
	input  wire logic                   offset_sel0_serial_bit,
	input  wire logic                   offset_select_third,
	input  wire logic                   port_a_strobe,
	input  wire logic                   port_a_write,
	input  wire logic                   port_a_mail_select,
	input  wire logic                   loopback_sel_n,
	input  wire logic [`DATA_W-1:0]     port_a_data_in,
	output logic [`DATA_W-1:0]          port_a_data_out,
	output logic                        port_a_data_oe_n,
	output logic                        port_a_tx_ready,
	input  wire logic [`DATA_W-1:0]     mailbox_two_data,
	output logic [`DATA_W-1:0]          mailbox_one_data,
	output logic                        mailbox_one_load,
	input  wire logic [`DATA_W-1:0]     rx_in_data,
	input  wire logic                   rx_in_valid,
	output logic                        rx_in_ready,
	output logic [`DATA_W-1:0]          tx_out_data,
	output logic                        tx_out_valid,
	input  wire logic                   tx_out_ready,
	output logic [OFS_W-1:0]            first_queue_offset_b,
	output logic [OFS_W-1:0]            first_queue_offset_a,
	output logic [OFS_W-1:0]            second_queue_offset_b,
	output logic [OFS_W-1:0]            second_queue_offset_a,
	output logic                        program_done,
	output logic                        loop_active,
	input  wire logic [`BUS_ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]            bus_wdata,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	output logic [31:0]                 bus_rdata
);
	localparam int CHAIN_W = `OFS_REG_COUNT * OFS_W;   // Bits in the whole offset chain.

	// Only the three depth variants are served: 44, 48 or 52 bit writes.
	if (OFS_W < 11 || OFS_W > 13) begin : g_bad_width
		$error("offset width must be 11, 12 or 13");
	end

	// ****************************************************************
	// State
	// ****************************************************************

	// All control state of the block.
	typedef struct packed {
		phase_t               phase;      // Strap, load or run.
		method_t              method;     // Chosen programming method.
		logic [CHAIN_W-1:0]   chain;      // Offsets B1, A1, B2, A2 from the top.
		logic [5:0]           count;      // Serial bits or parallel words loaded.
		logic [1:0]           ctrl;       // Software control bits.
		logic [`DATA_W-1:0]   rx_word;    // Receive queue output register.
		logic                 rx_full;    // The receive word is held.
		logic                 rx_ready;   // Registered ready to the receive queue.
		logic [`DATA_W-1:0]   a_out;      // Port A output data.
		logic                 a_oe_n;     // Port A output enable, low drives.
		logic [`DATA_W-1:0]   mbox_one;   // Mailbox one contents.
		logic                 mbox_load;  // Mailbox one written this cycle.
		logic                 loop;       // Loopback running.
		logic [31:0]          rdata;      // Register read data.
	} ctrl_state_t;

	ctrl_state_t          s_q;          // Registered state.
	ctrl_state_t          s_d;          // Next state.
	logic [`DATA_W-1:0]   fifo_in;      // Word offered to the transmit FIFO.
	logic                 fifo_valid;   // Offer strobe to the transmit FIFO.
	logic                 fifo_ready;   // Transmit FIFO has room.
	logic [$clog2(`TX_DEPTH):0] fifo_level; // Words held in the FIFO.

	// ********
	// Preset lookup
	// ********

	// Returns the default offset chosen by a preset strap code.
	function automatic logic [OFS_W-1:0] preset_value(input logic [2:0] code);
		logic [15:0] v;
		v = `PRESET_0;
		unique case (code)
			3'h0: v = `PRESET_0;
			3'h1: v = `PRESET_1;
			3'h2: v = `PRESET_2;
			3'h3: v = `PRESET_3;
			default: v = `PRESET_4;   // Only code 4 reaches here as a preset.
		endcase
		return v[OFS_W-1:0];
	endfunction

	// ********
	// Next state
	// ********

	// Computes every next value of the control state.
	always_comb begin
		logic [2:0]  strap;
		logic        rd_a;
		logic        wr_a;
		logic        loop_move;
		int          slot;
		strap      = {offset_select_third, offset_sel1_serial_load_en, offset_sel0_serial_bit};
		rd_a       = 1'b0;
		wr_a       = 1'b0;
		loop_move  = 1'b0;
		slot       = 0;
		s_d        = s_q;
		s_d.mbox_load = 1'b0;
		fifo_in    = port_a_data_in;
		fifo_valid = 1'b0;

		unique case (s_q.phase)
			// First edge after master reset: latch the method from the straps.
			PH_STRAP: begin
				s_d.count = '0;
				if (strap[2:1] == `STRAP_SERIAL) begin
					s_d.method = METHOD_SERIAL;
					s_d.phase  = PH_LOAD;
				end else if (strap == `STRAP_PARALLEL) begin
					s_d.method = METHOD_PARALLEL;
					s_d.phase  = PH_LOAD;
				end else begin
					s_d.method = METHOD_PRESET;
					s_d.chain  = {`OFS_REG_COUNT{preset_value(strap)}};
					s_d.phase  = PH_RUN;
				end
			end
			// Offsets are being programmed serially or over port A.
			PH_LOAD: begin
				if (s_q.method == METHOD_SERIAL) begin
					// Enable is active low and sampled on every edge.
					if (!offset_sel1_serial_load_en) begin
						s_d.chain = {s_q.chain[CHAIN_W-2:0], offset_sel0_serial_bit};
						s_d.count = s_q.count + 1'b1;
						if (s_q.count == 6'(CHAIN_W - 1)) begin
							s_d.phase = PH_RUN;
						end
					end
				end else if (port_a_strobe && port_a_write && !port_a_mail_select) begin
					// Each port A queue write fills the next offset register.
					slot = `OFS_REG_COUNT - 1 - int'(s_q.count[1:0]);
					s_d.chain[slot*OFS_W +: OFS_W] = port_a_data_in[OFS_W-1:0];
					s_d.count = s_q.count + 1'b1;
					if (s_q.count == 6'(`OFS_REG_COUNT - 1)) begin
						s_d.phase = PH_RUN;
					end
				end
			end
			// Normal operation: the queue and mailbox paths are open.
			PH_RUN: begin
				rd_a = port_a_strobe && !port_a_write;
				wr_a = port_a_strobe && port_a_write;
			end
			default: begin
				s_d.phase = PH_STRAP;   // Illegal code recovers through strap capture.
			end
		endcase

		// Loopback starts with select low and strobe high, then holds until allow clears.
		s_d.loop = (s_q.phase == PH_RUN) && s_q.ctrl[`CTRL_LOOP_ALLOW]
			&& (s_q.loop || (!loopback_sel_n && port_a_strobe));
		loop_move = s_q.loop && s_q.rx_full && fifo_ready;

		// Port A drives only on a read outside loopback.
		s_d.a_oe_n = !(rd_a && !s_q.loop);
		if (rd_a && !s_q.loop) begin
			if (port_a_mail_select) begin
				s_d.a_out = mailbox_two_data;
			end else if (s_q.rx_full) begin
				s_d.a_out   = s_q.rx_word;
				s_d.rx_full = 1'b0;
			end
		end

		// Receive data is steered into the transmit queue during loopback.
		if (loop_move) begin
			fifo_in     = s_q.rx_word;
			fifo_valid  = 1'b1;
			s_d.rx_full = 1'b0;
		end else if (wr_a && !s_q.loop) begin
			if (port_a_mail_select) begin
				s_d.mbox_one  = port_a_data_in;
				s_d.mbox_load = 1'b1;
			end else if (s_q.ctrl[`CTRL_QWRITE_EN]) begin
				fifo_valid = 1'b1;
			end
		end

		// The output register refills only when it is empty.
		if (rx_in_valid && s_q.rx_ready) begin
			s_d.rx_word = rx_in_data;
			s_d.rx_full = 1'b1;
		end
		s_d.rx_ready = !s_d.rx_full;

		// Register bus: control writes and read data both register at the next clock edge.
		if (bus_wr && bus_addr == `ADDR_CTRL) begin
			s_d.ctrl = bus_wdata[1:0];
		end
		s_d.rdata = '0;
		if (bus_rd) begin
			unique case (bus_addr)
				`ADDR_STATUS: begin
					s_d.rdata[`ST_METHOD_LSB +: 2] = s_q.method;
					s_d.rdata[`ST_DONE_BIT]        = (s_q.phase == PH_RUN);
					s_d.rdata[`ST_LOOP_BIT]        = s_q.loop;
					s_d.rdata[`ST_COUNT_LSB +: 6]  = s_q.count;
				end
				`ADDR_FIRST_B:  s_d.rdata[OFS_W-1:0] = s_q.chain[3*OFS_W +: OFS_W];
				`ADDR_FIRST_A:  s_d.rdata[OFS_W-1:0] = s_q.chain[2*OFS_W +: OFS_W];
				`ADDR_SECOND_B: s_d.rdata[OFS_W-1:0] = s_q.chain[OFS_W +: OFS_W];
				`ADDR_SECOND_A: s_d.rdata[OFS_W-1:0] = s_q.chain[0 +: OFS_W];
				`ADDR_CTRL:     s_d.rdata[1:0] = s_q.ctrl;
				`ADDR_LEVEL:    s_d.rdata[$clog2(`TX_DEPTH):0] = fifo_level;
				default:        s_d.rdata = '0;   // Unmapped addresses read zero.
			endcase
		end
	end

	// ********
	// State register
	// ********

	// Master reset clears the state but sets ctrl and a_oe_n; straps are taken at the first edge after.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q        <= '0;
			s_q.phase  <= PH_STRAP;
			s_q.method <= METHOD_PRESET;
			s_q.ctrl   <= `CTRL_RESET;
			s_q.a_oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Transmit queue input buffer
	// ****************************************************************

	// Holds words from port A or loopback until the transmit side drains them.
	tx_fifo #(
		.WIDTH (`DATA_W),
		.DEPTH (`TX_DEPTH)
	) u_tx_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_data   (fifo_in),
		.in_valid  (fifo_valid),
		.in_ready  (fifo_ready),
		.out_data  (tx_out_data),
		.out_valid (tx_out_valid),
		.out_ready (tx_out_ready),
		.level     (fifo_level)
	);

	// ********
	// Outputs
	// ********

	assign port_a_data_out       = s_q.a_out;
	assign port_a_data_oe_n      = s_q.a_oe_n;
	assign port_a_tx_ready       = fifo_ready;
	assign mailbox_one_data      = s_q.mbox_one;
	assign mailbox_one_load      = s_q.mbox_load;
	assign rx_in_ready           = s_q.rx_ready;
	assign first_queue_offset_b  = s_q.chain[3*OFS_W +: OFS_W];
	assign first_queue_offset_a  = s_q.chain[2*OFS_W +: OFS_W];
	assign second_queue_offset_b = s_q.chain[OFS_W +: OFS_W];
	assign second_queue_offset_a = s_q.chain[0 +: OFS_W];
	assign program_done          = (s_q.phase == PH_RUN);
	assign loop_active           = s_q.loop;
	assign bus_rdata             = s_q.rdata;
endmodule

/* verif/port_a_ctrl_monitor.sv */
// Checker for the port A offset, loopback and mailbox control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "port_a_ctrl_cfg.svh"

module port_a_ctrl_monitor
	import port_a_ctrl_pkg::*;
#(
	parameter int OFS_W = 11
) (
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic                   offset_sel1_serial_load_en,
	input wire logic                   offset_sel0_serial_bit,
	input wire logic                   offset_select_third,
	input wire logic                   port_a_strobe,
	input wire logic                   port_a_write,
	input wire logic                   port_a_mail_select,
	input wire logic                   loopback_sel_n,
	input wire logic [`DATA_W-1:0]     port_a_data_in,
	input wire logic [`DATA_W-1:0]     port_a_data_out,
	input wire logic                   port_a_data_oe_n,
	input wire logic [`DATA_W-1:0]     mailbox_two_data,
	input wire logic [`DATA_W-1:0]     mailbox_one_data,
	input wire logic                   mailbox_one_load,
	input wire logic [OFS_W-1:0]       first_queue_offset_b,
	input wire logic [OFS_W-1:0]       first_queue_offset_a,
	input wire logic [OFS_W-1:0]       second_queue_offset_a,
	input wire logic                   program_done,
	input wire logic                   loop_active,
	input wire logic [`BUS_ADDR_W-1:0] bus_addr,
	input wire logic [31:0]            bus_wdata,
	input wire logic                   bus_wr
);
	// ********
	// Helper state
	// ********
	logic        strap_seen_q; // High once the strap edge has passed.
	logic        serial_q;     // Serial method was strapped.
	logic        preset_q;     // A preset method was strapped.
	logic [15:0] preset_val_q; // Preset offset expected.
	logic [7:0]  shift_cnt_q;  // Enabled shifts seen so far.
	logic        loop_allow_q; // Shadow of the loop allow control bit.
	logic [2:0]  code;         // Strap pins as one code.

	assign code = {offset_select_third, offset_sel1_serial_load_en, offset_sel0_serial_bit};

	// Captures the strap code at its edge and counts serial shifts.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_seen_q <= 1'h0;
			serial_q     <= 1'h0;
			preset_q     <= 1'h0;
			preset_val_q <= 16'h0;
			shift_cnt_q  <= 8'h0;
			loop_allow_q <= 1'h1;
		end else begin
			if (bus_wr && bus_addr == `ADDR_CTRL) begin
				loop_allow_q <= bus_wdata[`CTRL_LOOP_ALLOW];
			end
			if (!strap_seen_q) begin
				strap_seen_q <= 1'h1;
				serial_q     <= code[2] && code[1];
				preset_q     <= code <= 3'h4;
				preset_val_q <= code == 3'h0 ? `PRESET_0 : code == 3'h1 ? `PRESET_1 :
					code == 3'h2 ? `PRESET_2 : code == 3'h3 ? `PRESET_3 : `PRESET_4;
			end else if (serial_q && !program_done && !offset_sel1_serial_load_en) begin
				shift_cnt_q <= shift_cnt_q + 8'h1;
			end
		end
	end

	// ********
	// Properties
	// ********
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_shift;
		serial_q && strap_seen_q && !program_done && !offset_sel1_serial_load_en;
	endsequence
	sequence s_mail_wr;
		program_done && port_a_strobe && port_a_write && port_a_mail_select && !loop_active && loopback_sel_n;
	endsequence

	property p_shift;
		s_shift |=> second_queue_offset_a == {$past(second_queue_offset_a[OFS_W-2:0]), $past(offset_sel0_serial_bit)}
			&& first_queue_offset_b == {$past(first_queue_offset_b[OFS_W-2:0]), $past(first_queue_offset_a[OFS_W-1])};
	endproperty
	property p_hold;
		serial_q && strap_seen_q && !program_done && offset_sel1_serial_load_en
			|=> $stable(first_queue_offset_b) && $stable(second_queue_offset_a);
	endproperty
	property p_count;
		$rose(program_done) && serial_q |-> shift_cnt_q == 4 * OFS_W;
	endproperty
	property p_stand;
		program_done |=> program_done && $stable(first_queue_offset_b) && $stable(second_queue_offset_a);
	endproperty
	property p_preset;
		$rose(strap_seen_q) && preset_q |-> program_done && first_queue_offset_b == preset_val_q[OFS_W-1:0]
			&& second_queue_offset_a == preset_val_q[OFS_W-1:0];
	endproperty
	property p_mail_wr;
		s_mail_wr |=> mailbox_one_load && mailbox_one_data == $past(port_a_data_in);
	endproperty
	property p_mail_rd;
		program_done && port_a_strobe && !port_a_write && port_a_mail_select && !loop_active && loopback_sel_n
			|=> !port_a_data_oe_n && port_a_data_out == $past(mailbox_two_data);
	endproperty
	property p_oe_cause;
		!port_a_data_oe_n |-> $past(port_a_strobe && !port_a_write && !loop_active);
	endproperty
	property p_loop_start;
		program_done && loop_allow_q && !loopback_sel_n && port_a_strobe |=> loop_active;
	endproperty
	property p_loop_quiet;
		loop_active |=> port_a_data_oe_n;
	endproperty

	a_shift: assert property (p_shift) else $error("serial shift wrong");
	a_hold: assert property (p_hold) else $error("shift while enable high");
	a_count: assert property (p_count) else $error("serial bit count wrong");
	a_stand: assert property (p_stand) else $error("offsets moved after load");
	a_preset: assert property (p_preset) else $error("preset offset wrong");
	a_mail_wr: assert property (p_mail_wr) else $error("mailbox write wrong");
	a_mail_rd: assert property (p_mail_rd) else $error("mailbox read wrong");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
	a_loop_start: assert property (p_loop_start) else $error("loopback not started");
	a_loop_quiet: assert property (p_loop_quiet) else $error("port read during loopback");
endmodule

bind port_a_offset_loop_mail_ctrl port_a_ctrl_monitor #(.OFS_W(OFS_W)) mon (.*);

/* verif/queue_side_model.sv */
// Receive queue source and transmit queue sink beside the port A control.
// Assumes one clock; stall stops the sink on command.
`timescale 1ns/1ps

module queue_side_model #(
	parameter logic [35:0] WORD_BASE = 36'h0_a5a5_0000
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        rx_en,
	input  wire logic        tx_stall,
	output logic [35:0]      rx_in_data,
	output logic             rx_in_valid,
	input  wire logic        rx_in_ready,
	input  wire logic [35:0] tx_out_data,
	input  wire logic        tx_out_valid,
	output logic             tx_out_ready
);
	logic [35:0] got [0:63]; // Words drained from the transmit side.
	int          got_n;      // Number of drained words.
	int          sent_n;     // Number of receive words handed over.

	// An idle line shows the inverse of the last word, never a stale copy.
	assign rx_in_data = rx_in_valid ? WORD_BASE + 36'(sent_n) : ~(WORD_BASE + 36'(sent_n) - 36'h1);

	// Offers words in order, holds each until taken, drains unless stalled.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sent_n       <= 0;
			got_n        <= 0;
			rx_in_valid  <= 1'h0;
			tx_out_ready <= 1'h0;
		end else begin
			if (rx_in_valid && rx_in_ready) begin
				sent_n <= sent_n + 1;
			end
			rx_in_valid  <= rx_en || (rx_in_valid && !rx_in_ready);
			tx_out_ready <= !tx_stall;
			if (tx_out_valid && tx_out_ready && got_n < 64) begin
				got[got_n] <= tx_out_data;
				got_n      <= got_n + 1;
			end
		end
	end
endmodule

/* verif/port_a_offset_loop_mail_ctrl_bench.sv */
// Self-checking bench for the port A offset, loopback and mailbox control.
// Assumes the queue side model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "port_a_ctrl_cfg.svh"

module port_a_offset_loop_mail_ctrl_bench
	import port_a_ctrl_pkg::*;
;
	logic sys_clk = 0, rst = 1, sen = 1, sbit = 0, third = 0, stb = 0, wr = 0, mail = 0, loop_n = 1;
	logic bwr = 0, brd = 0, rx_en = 0, stall = 1, oe_n, txr, mb1_ld, rxv, rxr, txv, txrdy, done, lact;
	logic [35:0] din = 0, mb2 = 0, dout, mb1, rxd, txd;
	logic [4:0]  addr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [10:0] b1, a1, b2, a2;
	int          mismatches = 0, check_count = 0;

	always #5 sys_clk = ~sys_clk;

	port_a_offset_loop_mail_ctrl #(.OFS_W(11)) dut (.sys_clk(sys_clk), .rst(rst),
		.offset_sel1_serial_load_en(sen), .offset_sel0_serial_bit(sbit), .offset_select_third(third),
		.port_a_strobe(stb), .port_a_write(wr), .port_a_mail_select(mail), .loopback_sel_n(loop_n),
		.port_a_data_in(din), .port_a_data_out(dout), .port_a_data_oe_n(oe_n), .port_a_tx_ready(txr),
		.mailbox_two_data(mb2), .mailbox_one_data(mb1), .mailbox_one_load(mb1_ld),
		.rx_in_data(rxd), .rx_in_valid(rxv), .rx_in_ready(rxr), .tx_out_data(txd), .tx_out_valid(txv),
		.tx_out_ready(txrdy), .first_queue_offset_b(b1), .first_queue_offset_a(a1),
		.second_queue_offset_b(b2), .second_queue_offset_a(a2), .program_done(done), .loop_active(lact),
		.bus_addr(addr), .bus_wdata(wdata), .bus_wr(bwr), .bus_rd(brd), .bus_rdata(rdata));

	queue_side_model qm (.sys_clk(sys_clk), .rst(rst), .rx_en(rx_en), .tx_stall(stall), .rx_in_data(rxd),
		.rx_in_valid(rxv), .rx_in_ready(rxr), .tx_out_data(txd), .tx_out_valid(txv), .tx_out_ready(txrdy));

	// ********
	// Shared tasks
	// ********
	task close_out;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [43:0] g, input logic [43:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task do_reset(input logic [2:0] s);
		@(posedge sys_clk) rst <= 1'h1;
		{third, sen, sbit} <= s;
		repeat (4) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk) {third, sen, sbit} <= 3'h2;
		#1;
	endtask
	task pa(input logic w, input logic m, input logic [35:0] d);
		@(posedge sys_clk) {stb, wr, mail, din} <= {1'h1, w, m, d};
		@(posedge sys_clk) stb <= 1'h0;
		#1;
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk) {bwr, brd, addr, wdata} <= {w, !w, a, d};
		@(posedge sys_clk) {bwr, brd} <= 2'h0;
		#1;
	endtask
	task wait_got(input int n);
		for (int i = 0; i < 300 && qm.got_n < n; i++) @(posedge sys_clk);
		if (qm.got_n < n) begin
			mismatches++;
			close_out();
		end
	endtask
	task req_loop;
		@(posedge sys_clk) {loop_n, stb, wr, mail} <= 4'h5;
		@(posedge sys_clk) {loop_n, stb} <= 2'h2;
		#1;
	endtask

	// ********
	// Scenarios
	// ********
	task t_presets;
		logic [10:0] pv [5];
		pv = '{11'h8, 11'h10, 11'h40, 11'h100, 11'h400};
		for (int c = 0; c < 5; c++) begin
			do_reset(3'(c));
			chk(done, 1'h1);
			chk(b1, pv[c]);
			chk(a2, pv[c]);
			bus(1'h0, `ADDR_STATUS, 32'h0);
			chk(rdata[1:0], 2'h0);
		end
		$display("presets finished");
	endtask
	task t_serial;
		logic [43:0] v;
		v = {11'h5a3, 11'h0f1, 11'h2c6, 11'h39e};
		do_reset(3'h6);
		for (int i = 0; i < 44; i++) begin
			@(posedge sys_clk) {sen, sbit} <= {1'h0, v[43-i]};
			if (i % 7 == 3) @(posedge sys_clk) sen <= 1'h1;
		end
		@(posedge sys_clk) sen <= 1'h1;
		#1 chk(done, 1'h1);
		chk({b1, a1, b2, a2}, v);
		repeat (3) @(posedge sys_clk) {sen, sbit} <= 2'h1;
		@(posedge sys_clk) sen <= 1'h1;
		#1 chk(a2, 11'h39e);
		bus(1'h0, `ADDR_FIRST_B, 32'h0);
		chk(rdata, 32'h5a3);
		bus(1'h0, `ADDR_STATUS, 32'h0);
		chk(rdata[2:0], 3'h6);
		$display("serial load finished");
	endtask
	task t_parallel_mail;
		do_reset(3'h5);
		for (int i = 1; i < 5; i++) pa(1'h1, 1'h0, 36'(11'h111 * i));
		chk(done, 1'h1);
		chk({b1, a1, b2, a2}, {11'h111, 11'h222, 11'h333, 11'h444});
		pa(1'h1, 1'h1, 36'h9_8765_4321);
		chk(mb1, 36'h9_8765_4321);
		chk(mb1_ld, 1'h1);
		@(posedge sys_clk) mb2 <= 36'h5_a5a5_a5a5;
		pa(1'h0, 1'h1, 36'h0);
		chk({oe_n, dout}, {1'h0, 36'h5_a5a5_a5a5});
		@(posedge sys_clk) rx_en <= 1'h1;
		repeat (3) @(posedge sys_clk);
		pa(1'h0, 1'h0, 36'h0);
		chk({oe_n, dout}, {1'h0, 36'h0_a5a5_0000});
		pa(1'h0, 1'h0, 36'h0);
		chk(dout, 36'h0_a5a5_0001);
		@(posedge sys_clk) rx_en <= 1'h0;
		$display("parallel and mailbox finished");
	endtask
	task t_fifo;
		int n;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			if (txr === 1'h1) n++;
			pa(1'h1, 1'h0, 36'h100 + 36'(i));
		end
		chk(n, 16);
		bus(1'h0, `ADDR_LEVEL, 32'h0);
		chk(rdata[4:0], 5'h10);
		@(posedge sys_clk) stall <= 1'h0;
		wait_got(16);
		for (int i = 0; i < 16; i++) chk(qm.got[i], 36'h100 + 36'(i));
		$display("transmit buffer finished");
	endtask
	task t_loop;
		int base;
		bus(1'h0, 5'h1c, 32'h0);
		chk(rdata, 32'h0);
		bus(1'h1, `ADDR_CTRL, 32'h2);
		req_loop();
		chk(lact, 1'h0);
		bus(1'h1, `ADDR_CTRL, 32'h3);
		bus(1'h0, `ADDR_CTRL, 32'h0);
		chk(rdata, 32'h3);
		base = qm.got_n;
		req_loop();
		chk(lact, 1'h1);
		pa(1'h0, 1'h1, 36'h0);
		chk(oe_n, 1'h1);
		@(posedge sys_clk) rx_en <= 1'h1;
		wait_got(base + 4);
		for (int k = 1; k < 4; k++) chk(qm.got[base+k], qm.got[base] + 36'(k));
		$display("loopback finished");
	endtask

	initial begin
		#1000000;
		mismatches++;
		close_out();
	end

	initial begin
		t_presets();
		t_serial();
		t_parallel_mail();
		t_fifo();
		t_loop();
		close_out();
	end
endmodule
